// [bench/schs_remote_model.sv]
// remote module stand-in: link state and process data, reloaded on request
`timescale 1ns/1ns
`default_nettype none
module schs_remote_model (
  input  wire logic        clk,
  input  wire logic        load,
  input  wire logic [31:0] rnd,
  input  wire logic [15:0] addr,
  output var  logic [7:0]  link_up   = 8'h00,
  output var  logic [7:0]  link_fail = 8'h00,
  output var  logic [47:0] in_bits   = 48'h0,
  output var  logic [15:0] fv        = 16'h0,
  output var  logic [47:0] ana       = 48'h0,
  output var  logic [15:0] word      = 16'h0,
  output var  logic [15:0] ptr       = 16'h0
);
  // descriptor image relative to the table pointer: one entry, one record
  function automatic logic [7:0] image(input logic [15:0] r);
    logic [15:0] rec;
    rec = ptr + 16'h0040;
    case (r)
      16'h0000: image = rec[7:0];
      16'h0001: image = rec[15:8];
      16'h0040: image = 8'ha0;
      16'h0041: image = 8'h30;
      16'h0042: image = 8'h01;
      16'h0044: image = 8'h11;
      16'h0048: image = 8'h22;
      16'h004a: image = 8'h33;
      16'h004c: image = 8'h56;
      16'h004e: image = 8'h69;
      16'h004f: image = 8'h6e;
      default:  image = 8'h00;
    endcase
  endfunction
  always @(posedge clk) begin
    word <= {image(addr - ptr + 16'h0001), image(addr - ptr)};
    if (load) begin
      link_up   <= rnd[7:0];
      link_fail <= rnd[15:8];
      in_bits   <= {rnd[23:8], ~rnd};
      fv        <= rnd[31:16];
      ana       <= {rnd[15:0], ~rnd};
      // nonzero, even and never wrapping into the record
      ptr       <= {1'b0, rnd[30:17], 1'b0} | 16'h0100;
    end
  end
endmodule
`default_nettype wire

// [bench/schs_sequencer_sva.sv]
// checker: apb handshake and halt behaviour of the sequencer
`timescale 1ns/1ns
`default_nettype none
module schs_sequencer_chk
  import schs_pkg::*;
(
  input wire logic                SYS_CLK,
  input wire logic                SYS_RST,
  input wire logic                PSEL,
  input wire logic                PENABLE,
  input wire logic                PWRITE,
  input wire logic [11:0]         PADDR,
  input wire logic [31:0]         PWDATA,
  input wire logic                PREADY,
  input wire logic                PSLVERR,
  input wire logic [CHANNELS-1:0] CHAN_RUN,
  input wire logic                PASS_THROUGH
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_halt;
    PREADY && PWRITE && PADDR == ADDR_COMMAND && PWDATA == {16'h0000, CMD_HALT_ALL};
  endsequence
  AST_READY_PULSE: assert property (PREADY |=> !PREADY) else $error("ready held too long");
  AST_READY_GATED: assert property (PREADY |-> PSEL && PENABLE) else $error("ready outside access");
  AST_WAIT_STATE: assert property (s_setup ##1 (PSEL && PENABLE) |-> PREADY)
    else $error("ready missing at first access edge");
  AST_SETUP_QUIET: assert property (s_setup |-> !PREADY) else $error("ready in setup cycle");
  AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  AST_UNMAPPED: assert property (PREADY && PADDR == 12'h010 |-> PSLVERR) else $error("no error on hole");
  AST_MAPPED: assert property (PREADY && PADDR == ADDR_DATA |-> !PSLVERR) else $error("error on data reg");
  AST_HALT_RUN: assert property (s_halt |-> ##[1:3] CHAN_RUN == '0) else $error("halt left channels");
  AST_HALT_PASS: assert property (s_halt |-> ##[1:3] !PASS_THROUGH) else $error("halt left setup");
endmodule
bind schs_sequencer schs_sequencer_chk u_chk (.SYS_CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PWDATA, .PREADY, .PSLVERR, .CHAN_RUN, .PASS_THROUGH);
`default_nettype wire

// [bench/schs_sequencer_tb.sv]
// self-checking bench for the channel sequencer
`timescale 1ns/1ns
`default_nettype none
module schs_sequencer_tb;
  import schs_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, load = 1'b1, prdy, perr, pt, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rnd, rd, m;
  logic [7:0]  up, fl, run;
  logic [47:0] bits, ana;
  logic [15:0] fv, word, ptr, e, ra = 16'h0000;
  logic [15:0] toc [$];
  int          fail_count = 0, checks_done = 0, cyc = 0, n, k;
  always #5 clk = ~clk;
  schs_sequencer #(.START_CYCLES(50)) u_dut (.SYS_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(prdy), .PSLVERR(perr),
    .LINK_UP(up), .LINK_FAIL(fl), .INPUT_BITS_IN(bits), .FIELD_VOLT_IN(fv), .ANALOG_IN(ana),
    .REMOTE_WORD_IN(word), .TABLE_PTR_IN(ptr), .CHAN_RUN(run), .PASS_THROUGH(pt));
  schs_remote_model u_rem (.clk(clk), .load(load), .rnd(rnd), .addr(ra), .link_up(up), .link_fail(fl),
    .in_bits(bits), .fv(fv), .ana(ana), .word(word), .ptr(ptr));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk) pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prdata;
    er = perr;
    psel <= 1'b0; pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic poll;
    n = 0;
    do begin
      apb(1'b0, ADDR_COMMAND, 32'h0);
      n++;
    end while (rd !== 32'h0);
  endtask
  // remote access on channel 0: opcode and address, trigger, wait, fault check, iface0 read
  task automatic remote(input logic [7:0] op, input logic [15:0] a);
    ra <= a;
    apb(1'b1, ADDR_CHAN_BASE | 12'h00c, {op, 8'h00, a});
    apb(1'b1, ADDR_COMMAND, 32'h1001);
    poll();
    apb(1'b0, ADDR_DATA, 32'h0); chk(rd, {31'h0, fl[0]});
    apb(1'b0, ADDR_CHAN_BASE, 32'h0);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    rnd = $urandom(72);
    repeat (6) @(posedge clk);
    rst <= 1'b0; load <= 1'b0;
    m = {24'h0, rnd[23:16] | 8'h01};
    @(posedge clk);
    apb(1'b0, ADDR_COMMAND, 32'h0); chk(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("reset test done");
    apb(1'b1, ADDR_COMMAND, 32'h800); poll();
    apb(1'b1, ADDR_COMMAND, 32'h900 | m); poll();
    apb(1'b0, ADDR_DATA, 32'h0); chk(rd, m & {24'h0, ~up});
    chk({24'h0, run}, m & {24'h0, up});
    apb(1'b0, ADDR_UNIT, 32'h0); chk(rd, UNIT_NUMBER_DEF);
    $display("start test done");
    apb(1'b1, ADDR_COMMAND, 32'h1000 | m);
    apb(1'b1, ADDR_COMMAND, 32'h10ff);
    apb(1'b0, ADDR_COMMAND, 32'h0); chk(rd, 32'h1000 | m);
    poll(); chk(32'(n * 5 <= TRIGGER_MAX_CYC), 32'h1);
    apb(1'b0, ADDR_DATA, 32'h0); chk(rd, m & {24'h0, fl});
    apb(1'b0, ADDR_CHAN_BASE, 32'h0); chk(rd, bits[31:0]);
    apb(1'b0, ADDR_CHAN_BASE | 12'h004, 32'h0); chk(rd, {fv, bits[47:32]});
    apb(1'b0, ADDR_UNIT, 32'h0); chk(rd, 32'h0);
    $display("trigger test done");
    apb(1'b1, ADDR_MODE, {30'h0, MODE_ANALOG});
    apb(1'b0, ADDR_MODE, 32'h0); chk(rd, {30'h0, MODE_ANALOG});
    apb(1'b1, ADDR_CHAN_BASE, ~rnd);
    apb(1'b1, ADDR_CHAN_BASE | 12'h004, rnd);
    apb(1'b1, ADDR_COMMAND, 32'h1000 | m); poll();
    apb(1'b0, ADDR_CHAN_BASE, 32'h0); chk(rd, bits[31:0]);
    apb(1'b0, ADDR_CHAN_BASE | 12'h004, 32'h0); chk(rd, {ana[15:0], bits[47:32]});
    apb(1'b0, ADDR_CHAN_BASE | 12'h008, 32'h0); chk(rd, ana[47:16]);
    apb(1'b0, ADDR_CHAN_BASE | 12'h00c, 32'h0);
    chk(rd, {7'h00, fl[0], 7'h00, up[0], 6'h00, MODE_ANALOG, 8'h00});
    apb(1'b1, ADDR_MODE, {30'h0, MODE_FIELD_V});
    apb(1'b1, ADDR_MODE, 32'h3);
    apb(1'b0, ADDR_MODE, 32'h0); chk(rd, {30'h0, MODE_FIELD_V});
    apb(1'b1, ADDR_COMMAND, 32'h1000 | m); poll();
    apb(1'b0, ADDR_CHAN_BASE | 12'h004, 32'h0); chk(rd, {fv, bits[47:32]});
    apb(1'b0, ADDR_CHAN_BASE | 12'h008, 32'h0); chk(rd, 32'h0);
    $display("mode test done");
    apb(1'b1, ADDR_COMMAND, 32'h800); poll(); chk({24'h0, run}, 32'h0);
    apb(1'b1, ADDR_COMMAND, 32'hf01); poll();
    chk({31'h0, pt}, 32'h1);
    apb(1'b0, ADDR_CHAN_BASE | 12'h008, 32'h0); chk(rd & 32'hffff, {16'h0, ptr});
    remote(8'h45, ptr); chk(rd, {16'h0, ptr + 16'h0040});
    e = ptr;
    while (rd[15:0] != 16'h0000 && toc.size() < 4) begin
      toc.push_back(rd[15:0]);
      e = e + 16'h0002;
      remote(8'h45, e);
    end
    chk(toc.size(), 32'h1);
    remote(8'h44, toc[0]); chk(rd & 32'hff, 32'ha0);
    remote(8'h44, toc[0] + 16'h0001); chk(rd & 32'hff, 32'h30);
    remote(8'h44, toc[0] + 16'h0002); chk(rd & 32'hff, 32'h01);
    remote(8'h44, toc[0] + 16'h0003); chk(rd & 32'hff, 32'h00);
    remote(8'h46, toc[0] + 16'h0004); chk(rd, 32'h0011);
    remote(8'h46, toc[0] + 16'h0008); chk(rd, 32'h0022);
    remote(8'h45, toc[0] + 16'h000a); chk(rd, 32'h0033);
    e = toc[0] + 16'h000c;
    k = 0;
    do begin
      remote(8'h44, e);
      e = e + 16'h0001;
      k++;
    end while (rd[7:0] != 8'h00 && k < 8);
    chk(k, 32'd2);
    k = 0;
    do begin
      remote(8'h44, e);
      e = e + 16'h0001;
      k++;
    end while (rd[7:0] != 8'h00 && k < 8);
    chk(k, 32'd3);
    $display("discovery test done");
    apb(1'b1, ADDR_CHAN_BASE, rnd);
    remote(8'h65, ptr); chk(rd, rnd);
    $display("setup test done");
    give_verdict();
  end
endmodule
`default_nettype wire

// [hw/schs_pkg.sv]
// package: register map, command codes and field layouts for the channel sequencer
package schs_pkg;
  localparam int unsigned CHANNELS         = 8;
  // byte addresses on the register bus
  localparam logic [11:0] ADDR_COMMAND     = 12'h000;
  localparam logic [11:0] ADDR_DATA        = 12'h004;
  localparam logic [11:0] ADDR_UNIT        = 12'h008;
  localparam logic [11:0] ADDR_MODE        = 12'h00c;
  localparam logic [11:0] ADDR_CHAN_BASE   = 12'h100;
  localparam logic [11:0] CHAN_STRIDE      = 12'h010;
  localparam logic [3:0]  OFS_IFACE0       = 4'h0;
  localparam logic [3:0]  OFS_IFACE1       = 4'h4;
  localparam logic [3:0]  OFS_IFACE2       = 4'h8;
  localparam logic [3:0]  OFS_CS           = 4'hc;
  // command register fields
  localparam logic [15:0] CMD_HALT_ALL     = 16'h0800;
  localparam logic [7:0]  CMD_OP_NSTART    = 8'h09;
  localparam logic [7:0]  CMD_OP_SSTART    = 8'h0f;
  localparam logic [7:0]  CMD_OP_TRIGGER   = 8'h10;
  localparam int unsigned CMD_IGNORE_BIT   = 15;
  // remote access opcodes in the control/status top byte
  localparam logic [7:0]  OP_READ_BYTE     = 8'h44;
  localparam logic [7:0]  OP_READ_DOUBLE   = 8'h47;
  localparam logic [7:0]  OP_WRITE_BYTE    = 8'h64;
  localparam logic [7:0]  OP_WRITE_DOUBLE  = 8'h67;
  // software modes of the remote module
  localparam logic [1:0]  MODE_INPUTS      = 2'h0;
  localparam logic [1:0]  MODE_ANALOG      = 2'h1;
  localparam logic [1:0]  MODE_FIELD_V     = 2'h2;
  localparam int unsigned INPUT_BITS       = 48;
  localparam int unsigned FIELD_V_BITS     = 16;
  // timing
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned TRIGGER_MAX_US   = 100;
  localparam int unsigned TRIGGER_MAX_CYC  = TRIGGER_MAX_US * CLK_MHZ;
  localparam int unsigned START_US         = 2000;
  localparam int unsigned START_CYC        = START_US * CLK_MHZ;
  localparam int unsigned XFER_CYC_DEF     = 64;
  localparam logic [31:0] UNIT_NUMBER_DEF  = 32'h0000_0001; // arbitrary value
  localparam logic [15:0] TABLE_PTR_DEF    = 16'h0000;

  typedef struct packed {
    logic [7:0] remote_fault;
    logic [7:0] comm_state;
    logic [7:0] status;
    logic [7:0] local_fault;
  } schs_cs_t;

  typedef struct packed {
    logic [31:0] iface2;
    logic [31:0] iface1;
    logic [31:0] iface0;
  } schs_payload_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_XFER  = 4'b0100,
    ST_HALT  = 4'b1000
  } schs_state_t;
endpackage

// [hw/schs_sequencer.sv]
// channel command sequencer with apb register file and remote channel model ports
`timescale 1ns/1ns
`default_nettype none
module schs_sequencer
  import schs_pkg::*;
#(
  parameter int unsigned START_CYCLES = START_CYC,
  parameter int unsigned XFER_CYCLES  = XFER_CYC_DEF,
  parameter logic [31:0] UNIT_NUMBER  = UNIT_NUMBER_DEF
) (
  input  wire logic                  SYS_CLK,
  input  wire logic                  SYS_RST,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [11:0]           PADDR,
  input  wire logic [31:0]           PWDATA,
  output logic      [31:0]           PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  input  wire logic [CHANNELS-1:0]   LINK_UP,
  input  wire logic [CHANNELS-1:0]   LINK_FAIL,
  input  wire logic [47:0]           INPUT_BITS_IN,
  input  wire logic [15:0]           FIELD_VOLT_IN,
  input  wire logic [47:0]           ANALOG_IN,
  input  wire logic [15:0]           REMOTE_WORD_IN,
  input  wire logic [15:0]           TABLE_PTR_IN,
  output logic      [CHANNELS-1:0]   CHAN_RUN,
  output logic                       PASS_THROUGH
);
  localparam int unsigned CW = $clog2(START_CYCLES + TRIGGER_MAX_CYC + XFER_CYCLES + 2);

  schs_state_t             state_q;
  logic [15:0]             command_q;
  logic [CHANNELS-1:0]     data_q;
  logic [CHANNELS-1:0]     mask_q;
  logic                    setup_q;
  logic                    triggered_q;
  logic [1:0]              mode_q;
  logic [CW-1:0]           count_q;
  schs_payload_t           payload_q [CHANNELS];
  schs_cs_t                cs_q [CHANNELS];
  logic [31:0]             prdata_q;
  logic                    pready_q;
  logic                    pslverr_q;

  wire  access   = PSEL && PENABLE && pready_q;
  wire  wr       = access && PWRITE;
  wire  chan_hit = PADDR >= ADDR_CHAN_BASE && PADDR < ADDR_CHAN_BASE + CHAN_STRIDE * 12'(CHANNELS);
  wire  [11:0] chan_off = PADDR - ADDR_CHAN_BASE;
  wire  [2:0]  chan_idx = chan_off[6:4];
  wire  [3:0]  reg_off  = chan_off[3:0];
  wire  cmd_wr   = wr && PADDR == ADDR_COMMAND;
  // writes to a busy command register are dropped unless halt; writes with the ignore bit set are always dropped
  wire  cmd_take = cmd_wr && !PWDATA[CMD_IGNORE_BIT]
                   && (command_q == 16'h0000 || PWDATA[15:0] == CMD_HALT_ALL);

  function automatic logic remote_op(input logic [7:0] op);
    remote_op = (op >= OP_READ_BYTE && op <= OP_READ_DOUBLE)
             || (op >= OP_WRITE_BYTE && op <= OP_WRITE_DOUBLE);
  endfunction

  // apb: ready on the first access edge, every address answered
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= PSEL && !pready_q;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      if (PSEL && !pready_q && !PWRITE) begin
        if (PADDR == ADDR_COMMAND) begin
          prdata_q <= {16'h0000, command_q};
        end else if (PADDR == ADDR_DATA) begin
          prdata_q <= {24'h000000, data_q};
        end else if (PADDR == ADDR_UNIT) begin
          prdata_q <= triggered_q ? 32'h0000_0000 : UNIT_NUMBER;
        end else if (PADDR == ADDR_MODE) begin
          prdata_q <= {30'h0, mode_q};
        end else if (chan_hit) begin
          case (reg_off)
            OFS_IFACE0: prdata_q <= payload_q[chan_idx].iface0;
            OFS_IFACE1: prdata_q <= payload_q[chan_idx].iface1;
            OFS_IFACE2: prdata_q <= payload_q[chan_idx].iface2;
            OFS_CS:     prdata_q <= cs_q[chan_idx];
            default:    pslverr_q <= 1'b1;
          endcase
        end else begin
          pslverr_q <= 1'b1;
        end
      end
    end
  end

  // command sequencer
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      state_q     <= ST_IDLE;
      command_q   <= 16'h0000;
      data_q      <= '0;
      mask_q      <= '0;
      setup_q     <= 1'b0;
      triggered_q <= 1'b0;
      count_q     <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cmd_take) begin
            command_q <= PWDATA[15:0];
            mask_q    <= PWDATA[7:0];
            count_q   <= '0;
            if (PWDATA[15:0] == CMD_HALT_ALL) begin
              state_q <= ST_HALT;
            end else if (PWDATA[15:8] == CMD_OP_NSTART || PWDATA[15:8] == CMD_OP_SSTART) begin
              setup_q     <= PWDATA[15:8] == CMD_OP_SSTART;
              triggered_q <= 1'b0;
              state_q     <= ST_START;
            end else if (PWDATA[15:8] == CMD_OP_TRIGGER) begin
              triggered_q <= 1'b1;
              state_q     <= ST_XFER;
            end else begin
              command_q <= 16'h0000;
            end
          end
        end
        ST_START: begin
          count_q <= count_q + 1'b1;
          if (count_q >= CW'(START_CYCLES) || (mask_q & LINK_UP) == mask_q) begin
            data_q    <= mask_q & ~LINK_UP;
            command_q <= 16'h0000;
            state_q   <= ST_IDLE;
          end
        end
        ST_XFER: begin
          count_q <= count_q + 1'b1;
          // finish well inside the trigger bound
          if (count_q >= CW'(XFER_CYCLES - 1) || count_q >= CW'(TRIGGER_MAX_CYC - 1)) begin
            data_q    <= mask_q & LINK_FAIL;
            command_q <= 16'h0000;
            state_q   <= ST_IDLE;
          end
        end
        ST_HALT: begin
          setup_q   <= 1'b0;
          command_q <= 16'h0000;
          state_q   <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
      if (cmd_take && state_q != ST_IDLE && PWDATA[15:0] == CMD_HALT_ALL) begin
        command_q <= PWDATA[15:0];
        state_q   <= ST_HALT;
      end
    end
  end

  // software mode register, inputs-only after reset
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      mode_q <= MODE_INPUTS;
    end else if (wr && PADDR == ADDR_MODE && PWDATA[1:0] <= MODE_FIELD_V) begin
      mode_q <= PWDATA[1:0];
    end
  end

  // per-channel interface and control/status registers
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      for (int i = 0; i < CHANNELS; i++) begin
        payload_q[i] <= '0;
        cs_q[i]      <= '0;
      end
    end else begin
      if (wr && chan_hit) begin
        case (reg_off)
          OFS_IFACE0: payload_q[chan_idx].iface0 <= PWDATA;
          OFS_IFACE1: payload_q[chan_idx].iface1 <= PWDATA;
          OFS_IFACE2: payload_q[chan_idx].iface2 <= PWDATA;
          OFS_CS:     cs_q[chan_idx] <= PWDATA;
          default:    ;
        endcase
      end
      for (int i = 0; i < CHANNELS; i++) begin
        if (state_q == ST_START && (count_q >= CW'(START_CYCLES) || (mask_q & LINK_UP) == mask_q)
            && mask_q[i] && setup_q) begin
          payload_q[i].iface2 <= {16'h0000, TABLE_PTR_IN};
        end
        if (state_q == ST_XFER && count_q >= CW'(XFER_CYCLES - 1) && mask_q[i]) begin
          cs_q[i] <= '{remote_fault: {7'h00, LINK_FAIL[i]}, comm_state: {7'h00, LINK_UP[i]},
                       status: {6'h00, mode_q}, local_fault: 8'h00};
          if (setup_q) begin
            if (remote_op(cs_q[i][31:24]) && cs_q[i][31:24] <= OP_READ_DOUBLE) begin
              payload_q[i].iface0 <= {16'h0000, REMOTE_WORD_IN};
            end
          end else begin
            // lsb-first packing, iface0 then iface1
            payload_q[i].iface0 <= INPUT_BITS_IN[31:0];
            payload_q[i].iface1 <= (mode_q == MODE_ANALOG) ? {ANALOG_IN[15:0], INPUT_BITS_IN[47:32]}
                                                           : {FIELD_VOLT_IN, INPUT_BITS_IN[47:32]};
            // analog bytes continue past the 48 input bits
            payload_q[i].iface2 <= (mode_q == MODE_ANALOG) ? ANALOG_IN[47:16] : 32'h0000_0000;
          end
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      CHAN_RUN     <= '0;
      PASS_THROUGH <= 1'b0;
    end else begin
      CHAN_RUN     <= (state_q == ST_HALT) ? '0 : (state_q == ST_START ? mask_q & LINK_UP : CHAN_RUN);
      PASS_THROUGH <= setup_q;
    end
  end

  assign PRDATA  = prdata_q;
  assign PREADY  = pready_q;
  assign PSLVERR = pslverr_q;
endmodule
`default_nettype wire
